// File: verilog/rns_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// - supply out of tolerance keeps the processor reset low indefinitely.
// - after supply recovers, reset stays low another 350 ms.
// - reset button is debounced; its release starts a 350 ms reset.
// - at reset release a high interrupt line selects power-on reset.
// - a low interrupt line at reset release selects manual reset.
// - interrupt is edge triggered; a select bit picks rising or falling.
// - edge select clears to 0; at 0 a falling edge interrupts.
// - interrupt latch rests high, goes low while pressed, ignores bounces.
// - an interrupt edge during reset is dropped, not raised later.
// - a source select routes the latch or an external line.
module rns_sequencer #(
  parameter int unsigned STRETCH_CYCLES = rns_pkg::STRETCH_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = rns_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic supply_ok,
  input wire logic reset_pushbutton_n,
  input wire logic interrupt_pushbutton_n,
  input wire logic external_nmi,
  input wire logic interrupt_source_select,
  input wire logic nmi_edge_select,
  output rns_pkg::rns_rstinfo_t rst_info,
  output logic nmi_level,
  output logic nmi_irq
);

  rns_pkg::rns_state_t st;
  rns_pkg::rns_state_t next_st;
  logic btn_released;
  logic nmi_latch;
  logic nmi_line;
  logic rise;
  logic fall;
  logic active_edge;
  logic supply_good;
  logic button_up;
  logic stretch_done;

  rns_debounce #(
    .STABLE_CYCLES(DEBOUNCE_CYCLES)
  ) u_reset_btn (
    .clk(clk),
    .rstn(rstn),
    .raw(reset_pushbutton_n),
    .level(btn_released)
  );

  rns_debounce #(
    .STABLE_CYCLES(DEBOUNCE_CYCLES)
  ) u_nmi_btn (
    .clk(clk),
    .rstn(rstn),
    .raw(interrupt_pushbutton_n),
    .level(nmi_latch)
  );

  always_comb begin
    next_st = st;
    next_st.sup_ff1 = supply_ok;
    next_st.sup_ff2 = st.sup_ff1;
    next_st.ext_ff1 = external_nmi;
    next_st.ext_ff2 = st.ext_ff1;
    next_st.sel_ff1 = interrupt_source_select;
    next_st.sel_ff2 = st.sel_ff1;

    // interrupt source select
    // the external path relies on the pad pull-up; unconnected it reads high
    nmi_line = st.sel_ff2 ? st.ext_ff2 : nmi_latch;

    rise = nmi_line & ~st.nmi_prev;
    fall = ~nmi_line & st.nmi_prev;
    active_edge = st.edge_sel ? rise : fall;
    next_st.nmi_prev = nmi_line;

    supply_good = st.sup_ff2;
    button_up = btn_released;
    stretch_done = rns_pkg::cnt_done(st.cnt, STRETCH_CYCLES);
    next_st.info.por_start = 1'b0;
    next_st.info.manual_start = 1'b0;

    case (st.fsm)
      rns_pkg::RNS_HOLD: begin
        // reset held while supply is bad
        next_st.cnt = '0;
        if (supply_good && button_up) begin
          next_st.fsm = rns_pkg::RNS_STRETCH;
        end
      end
      rns_pkg::RNS_STRETCH: begin
        if (!supply_good || !button_up) begin
          next_st.fsm = rns_pkg::RNS_HOLD;
          next_st.cnt = '0;
        end else if (stretch_done) begin
          next_st.fsm = rns_pkg::RNS_RUN;
          next_st.cnt = '0;
          next_st.info.kind_por = nmi_line;
          next_st.info.por_start = nmi_line;
          next_st.info.manual_start = ~nmi_line;
        end else begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end
      rns_pkg::RNS_RUN: begin
        next_st.cnt = '0;
        if (!supply_good || !button_up) begin
          next_st.fsm = rns_pkg::RNS_HOLD;
        end
      end
      default: begin
        next_st.fsm = rns_pkg::RNS_HOLD;
        next_st.cnt = '0;
      end
    endcase

    next_st.info.cpu_reset_n = (next_st.fsm == rns_pkg::RNS_RUN);

    next_st.edge_sel = st.info.cpu_reset_n & nmi_edge_select;

    // no interrupt around reset
    // prev keeps tracking during reset, so an edge seen there is never replayed
    next_st.irq = active_edge && (st.fsm == rns_pkg::RNS_RUN)
                  && (next_st.fsm == rns_pkg::RNS_RUN);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= rns_pkg::STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rst_info = st.info;
  assign nmi_level = st.nmi_prev;
  assign nmi_irq = st.irq;

  default clocking seq_cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_supply_holds_reset: assert property (
    !st.sup_ff2 |=> !rst_info.cpu_reset_n)
    else $error("reset released while supply is bad");

  a_stretch_length: assert property (
    $rose(rst_info.cpu_reset_n) |-> ($past(st.fsm) == rns_pkg::RNS_STRETCH)
                                    && rns_pkg::cnt_done($past(st.cnt), STRETCH_CYCLES))
    else $error("reset released without a full stretch");

  a_stretch_holds: assert property (
    (st.fsm == rns_pkg::RNS_STRETCH) && !stretch_done |=> !rst_info.cpu_reset_n)
    else $error("reset released during the stretch");

  a_button_holds: assert property (
    !btn_released |=> !rst_info.cpu_reset_n ##1 !rst_info.cpu_reset_n)
    else $error("reset released while button held");

  a_release_restarts: assert property (
    $rose(btn_released) && st.sup_ff2
    |=> (st.fsm == rns_pkg::RNS_STRETCH) && (st.cnt == '0))
    else $error("button release did not start the stretch");

  a_por_type: assert property (
    $rose(rst_info.cpu_reset_n) && $past(nmi_line)
    |-> rst_info.por_start && rst_info.kind_por && !rst_info.manual_start)
    else $error("high interrupt line did not give power-on reset");

  a_manual_type: assert property (
    $rose(rst_info.cpu_reset_n) && !$past(nmi_line)
    |-> rst_info.manual_start && !rst_info.kind_por && !rst_info.por_start)
    else $error("low interrupt line did not give manual reset");

  a_edge_polarity: assert property (
    nmi_irq |-> ($past(st.edge_sel) ? ($past(nmi_line) && !$past(st.nmi_prev))
                                    : (!$past(nmi_line) && $past(st.nmi_prev))))
    else $error("interrupt raised on the wrong edge");

  a_select_cleared: assert property (
    !rst_info.cpu_reset_n |=> !st.edge_sel)
    else $error("edge select not cleared by reset");

  a_fall_raises: assert property (
    (st.fsm == rns_pkg::RNS_RUN) && st.sup_ff2 && btn_released && !st.edge_sel && fall
    |=> nmi_irq)
    else $error("falling edge did not raise the interrupt");

  a_no_irq_in_reset: assert property (
    !rst_info.cpu_reset_n |=> !nmi_irq)
    else $error("interrupt raised from an edge seen in reset");

  a_source_route: assert property (
    st.sel_ff2 && $stable(st.sel_ff2) |=> nmi_level == $past(st.ext_ff2))
    else $error("external source not routed to the interrupt line");

  a_irq_single: assert property (
    nmi_irq |=> !nmi_irq)
    else $error("interrupt pulse longer than one cycle");

  a_kind_kept: assert property (
    !$rose(rst_info.cpu_reset_n) |-> $stable(rst_info.kind_por))
    else $error("reset type changed outside a reset release");

  a_stretch_counts: assert property (
    (st.fsm == rns_pkg::RNS_STRETCH) && supply_good && button_up && !stretch_done
    |=> (st.cnt == $past(st.cnt) + 1'b1))
    else $error("stretch count skipped a cycle");

  c_power_on: cover property ($rose(rst_info.cpu_reset_n) && rst_info.por_start);
  c_manual: cover property ($rose(rst_info.cpu_reset_n) && rst_info.manual_start);
  c_irq: cover property (nmi_irq);
  c_supply_drop: cover property (rst_info.cpu_reset_n ##1 !st.sup_ff2);
  c_external_irq: cover property (st.sel_ff2 && nmi_irq);

endmodule // rns_sequencer

// File: inc/rns_pkg.sv
package rns_pkg;

  // timing base: 25 MHz system clock expressed in kHz so products stay in 32 bits
  localparam int unsigned CLK_KHZ = 25000;
  localparam int unsigned STRETCH_MS = 350;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned STRETCH_CYCLES = STRETCH_MS * CLK_KHZ;
  localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_KHZ;

  // wide enough for 8,750,000 cycles
  localparam int unsigned CNT_W = 24;
  typedef logic [CNT_W-1:0] rns_cnt_t;

  typedef enum logic [2:0] {
    RNS_HOLD = 3'h1,
    RNS_STRETCH = 3'h2,
    RNS_RUN = 3'h4
  } rns_fsm_t;

  typedef struct packed {
    logic cpu_reset_n;
    logic por_start;
    logic manual_start;
    logic kind_por;
  } rns_rstinfo_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic level;
    rns_cnt_t cnt;
  } rns_deb_t;

  typedef struct packed {
    rns_fsm_t fsm;
    rns_cnt_t cnt;
    logic sup_ff1;
    logic sup_ff2;
    logic ext_ff1;
    logic ext_ff2;
    logic sel_ff1;
    logic sel_ff2;
    logic nmi_prev;
    logic edge_sel;
    logic irq;
    rns_rstinfo_t info;
  } rns_state_t;

  // buttons rest released (high), the latch rests high
  localparam rns_deb_t DEB_RESET = '{sync1: 1'b1, sync2: 1'b1, level: 1'b1, cnt: '0};

  // supply counts as bad until seen good; external line rests high through its pull-up
  localparam rns_rstinfo_t INFO_RESET = '{cpu_reset_n: 1'b0, por_start: 1'b0,
                                          manual_start: 1'b0, kind_por: 1'b1};
  localparam rns_state_t STATE_RESET = '{fsm: RNS_HOLD, cnt: '0,
                                         sup_ff1: 1'b0, sup_ff2: 1'b0,
                                         ext_ff1: 1'b1, ext_ff2: 1'b1,
                                         sel_ff1: 1'b0, sel_ff2: 1'b0,
                                         nmi_prev: 1'b1, edge_sel: 1'b0, irq: 1'b0,
                                         info: INFO_RESET};

  function automatic logic cnt_done(input rns_cnt_t cnt, input int unsigned n);
    return cnt == CNT_W'(n - 1);
  endfunction

endpackage

// File: verilog/rns_debounce.sv
`timescale 1ns/1ps
module rns_debounce #(
  parameter int unsigned STABLE_CYCLES = rns_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic raw,
  output logic level
);

  rns_pkg::rns_deb_t st;
  rns_pkg::rns_deb_t next_st;

  always_comb begin
    next_st = st;
    next_st.sync1 = raw;
    next_st.sync2 = st.sync1;
    // stable-time filter
    // a contact bounce restarts the count, so one press gives exactly one change
    if (st.sync2 == st.level) begin
      next_st.cnt = '0;
    end else if (rns_pkg::cnt_done(st.cnt, STABLE_CYCLES)) begin
      next_st.level = st.sync2;
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= rns_pkg::DEB_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;

  default clocking deb_cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_level_settles: assert property (
    $changed(st.level) |-> rns_pkg::cnt_done($past(st.cnt), STABLE_CYCLES)
                           && ($past(st.sync2) == st.level))
    else $error("debounced level changed before the input was stable");

  a_bounce_restarts: assert property (
    (st.sync2 == st.level) |=> (st.cnt == '0) && $stable(st.level))
    else $error("debounce count not restarted by a bounce");

endmodule // rns_debounce

// File: dv/rns_far_side.sv
`timescale 1ns/1ps
module rns_far_side (
  input wire logic clk,
  output logic supply_ok,
  output logic reset_pushbutton_n,
  output logic interrupt_pushbutton_n,
  output logic external_nmi
);
  // supply starts bad, buttons released
  initial begin
    supply_ok = 1'b0;
    reset_pushbutton_n = 1'b1;
    interrupt_pushbutton_n = 1'b1;
    external_nmi = 1'b1;
  end

  task automatic set_supply(input logic v);
    @(posedge clk);
    #1;
    supply_ok = v;
  endtask

  task automatic set_ext(input logic v);
    @(posedge clk);
    #1;
    external_nmi = v;
  endtask

  // contacts chatter on closure only, so a release is clean
  task automatic press(input logic nmi_btn, input logic v);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      #1;
      if (nmi_btn) interrupt_pushbutton_n = v | i[0];
      else reset_pushbutton_n = v | i[0];
    end
  endtask
endmodule // rns_far_side

// File: dv/tb_rns_sequencer.sv
`timescale 1ns/1ps
module tb_rns_sequencer;
  localparam int STRETCH = 20;
  localparam int DEB = 4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic nmi_edge_select = 1'b0;
  logic interrupt_source_select = 1'b0;
  wire logic supply_ok;
  wire logic rst_btn_n;
  wire logic nmi_btn_n;
  wire logic ext_nmi;
  rns_pkg::rns_rstinfo_t info;
  logic nmi_level;
  logic nmi_irq;
  int error_cnt = 0;
  int total_checks = 0;
  int irqs;
  int first;
  int n;

  always #20 clk = ~clk;

  rns_far_side far (.clk(clk), .supply_ok(supply_ok), .reset_pushbutton_n(rst_btn_n),
    .interrupt_pushbutton_n(nmi_btn_n), .external_nmi(ext_nmi));

  rns_sequencer #(.STRETCH_CYCLES(STRETCH), .DEBOUNCE_CYCLES(DEB)) uut (.clk(clk),
    .rstn(rstn), .supply_ok(supply_ok), .reset_pushbutton_n(rst_btn_n),
    .interrupt_pushbutton_n(nmi_btn_n), .external_nmi(ext_nmi),
    .interrupt_source_select(interrupt_source_select), .nmi_edge_select(nmi_edge_select),
    .rst_info(info), .nmi_level(nmi_level), .nmi_irq(nmi_irq));

  task automatic chk(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_cnt(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic watch(input int cyc);
    irqs = 0;
    first = 0;
    for (int i = 1; i <= cyc; i++) begin
      @(posedge clk);
      #1;
      if (nmi_irq === 1'b1) begin
        irqs++;
        if (first == 0) first = i;
      end
    end
  endtask

  // bounded so a stuck reset cannot hang the run
  task automatic wait_run();
    n = 0;
    while (info.cpu_reset_n !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic t_power();
    // select raised while held in reset must stay cleared inside
    nmi_edge_select = 1'b1;
    watch(30);
    chk("cpu_reset_n", 1'b0, info.cpu_reset_n);
    far.set_supply(1'b1);
    wait_run();
    chk_cnt("stretch", STRETCH + 3, n);
    chk("por_start", 1'b1, info.por_start);
    chk("kind_por", 1'b1, info.kind_por);
    far.set_supply(1'b0);
    repeat (3) @(posedge clk);
    #1;
    chk("cpu_reset_n", 1'b0, info.cpu_reset_n);
    far.set_supply(1'b1);
    wait_run();
    chk_cnt("stretch", STRETCH + 3, n);
    $display("power test done");
  endtask

  task automatic t_button();
    nmi_edge_select = 1'b0;
    far.press(1'b0, 1'b0);
    watch(12);
    chk("cpu_reset_n", 1'b0, info.cpu_reset_n);
    far.press(1'b0, 1'b1);
    wait_run();
    // release lands on the first of five press edges: 2 sync + DEB + 1 + STRETCH - 4
    chk_cnt("stretch", STRETCH + DEB - 1, n);
    chk("por_start", 1'b1, info.por_start);
    $display("button test done");
  endtask

  // reset held, line dropped, reset released, then line restored
  task automatic t_manual();
    far.press(1'b0, 1'b0);
    far.press(1'b1, 1'b0);
    watch(DEB + 6);
    far.press(1'b0, 1'b1);
    wait_run();
    chk("manual_start", 1'b1, info.manual_start);
    chk("por_start", 1'b0, info.por_start);
    chk("kind_por", 1'b0, info.kind_por);
    // a replayed edge from reset would show in the first cycles after release
    watch(4);
    chk_cnt("irq_after_release", 0, irqs);
    far.press(1'b1, 1'b1);
    watch(20);
    chk_cnt("irq_count", 0, irqs);
    $display("manual test done");
  endtask

  task automatic t_edges();
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      #1;
      nmi_edge_select = s[0];
      far.press(1'b1, 1'b0);
      watch(20);
      chk_cnt("irq_on_fall", int'(s == 0), irqs);
      chk("nmi_level", 1'b0, nmi_level);
      far.press(1'b1, 1'b1);
      watch(20);
      chk_cnt("irq_on_rise", s, irqs);
      chk("nmi_level", 1'b1, nmi_level);
    end
    $display("edge test done");
  endtask

  task automatic t_external();
    @(posedge clk);
    #1;
    nmi_edge_select = 1'b0;
    interrupt_source_select = 1'b1;
    far.press(1'b1, 1'b0);
    watch(20);
    chk_cnt("irq_latch_unselected", 0, irqs);
    far.set_ext(1'b0);
    watch(10);
    chk_cnt("irq_latency", 3, first);
    chk_cnt("irq_count", 1, irqs);
    chk("nmi_level", 1'b0, nmi_level);
    far.set_ext(1'b1);
    far.press(1'b1, 1'b1);
    $display("external test done");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_power();
    t_button();
    t_manual();
    t_edges();
    t_external();
    summarize();
  end

  // all tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule // tb_rns_sequencer
